// ==== logic/vectored_priority_interrupt_front.sv ====
// Local design decisions: the address map and the Wishbone register port.
`timescale 1ns/1ps
module vectored_priority_interrupt_front
  import irq_front_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire wb_req_s wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic fast_irq_pin,
  input wire logic [SYS_LINES-1:0] sys_irq_lines,
  input wire logic [NPER-1:0] periph_irq,
  input wire logic [NEXT-1:0] ext_irq_pin,
  output logic fast_request_n,
  output logic normal_request_n,
  output logic wake_req
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] onehot(input logic [4:0] n);
    onehot = 32'h00000001 << n;
  endfunction

  // Highest priority wins; scanning down makes ties go low
  function automatic pick_s pick_best(
    input logic [31:0] cand,
    input logic [NSRC-1:0][2:0] pr
  );
    pick_s r;
    r = '0;
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (cand[i] && (!r.found || pr[i] >= r.prio))
      begin
        r.found = 1'b1;
        r.id = 5'(i);
        r.prio = pr[i];
      end
    end
    pick_best = r;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [NSRC-1:0][2:0] prio_reg;
  logic [NSRC-1:0][1:0] trig_reg;
  logic [31:0] mask_reg;
  logic [31:0] force_reg;
  logic gmask_reg;
  logic [4:0] stk_src_reg [STACK_DEPTH];
  logic [2:0] stk_pri_reg [STACK_DEPTH];
  logic [3:0] sp_reg;
  logic [31:0] rdata_reg;
  logic ack_reg;
  logic fast_n_reg;
  logic normal_n_reg;
  logic wake_reg;
  logic [31:0] pend;

  // ----------------------------------------------------------------
  // Source wiring
  // ----------------------------------------------------------------
  // Bit index is the peripheral identifier [RULE_13]
  // Source 0 is the fast pin, source 1 the system OR
  wire [31:0] src_raw = {ext_irq_pin, periph_irq, // [RULE_12]
                         |sys_irq_lines, // [RULE_11]
                         fast_irq_pin}; // [RULE_10]

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire acc = wb_i.cyc & wb_i.stb & ~ack_reg;
  wire wr = acc & wb_i.we;
  wire rd = acc & ~wb_i.we;
  wire [11:0] adr = wb_i.adr;
  wire [31:0] bmask = {{8{wb_i.sel[3]}}, {8{wb_i.sel[2]}},
                       {8{wb_i.sel[1]}}, {8{wb_i.sel[0]}}};
  wire [31:0] wdat = wb_i.dat & bmask;

  wire hit_mode = (adr <= OFS_MODE_LAST) & (adr[1:0] == 2'b00);
  wire [4:0] mode_idx = adr[6:2];
  wire mode_wr = wr & hit_mode & wb_i.sel[0];
  wire vec_rd = rd & (adr == OFS_VECTOR);
  wire fvec_rd = rd & (adr == OFS_FAST_VECTOR);
  wire en_wr = wr & (adr == OFS_ENABLE);
  wire dis_wr = wr & (adr == OFS_DISABLE);
  wire set_wr = wr & (adr == OFS_SET);
  wire clr_wr = wr & (adr == OFS_CLEAR);
  wire end_wr = wr & (adr == OFS_END);
  wire gm_wr = wr & (adr == OFS_GMASK) & wb_i.sel[0];
  wire fon_wr = wr & (adr == OFS_FORCE_ON);
  wire foff_wr = wr & (adr == OFS_FORCE_OFF);

  // ----------------------------------------------------------------
  // Priority resolution
  // ----------------------------------------------------------------
  // Source 0 is always fast, so its force bit reads as set
  wire [31:0] force_eff = force_reg | 32'h00000001;
  wire [31:0] active = pend & mask_reg; // [RULE_01]
  wire [31:0] norm_cand = active & ~force_eff; // [RULE_06]
  wire pick_s best = pick_best(norm_cand, prio_reg); // [RULE_16] [RULE_17]
  wire [2:0] top_idx = 3'(sp_reg - 4'h1);
  wire [2:0] cur_pri = stk_pri_reg[top_idx];
  wire [4:0] cur_id = (sp_reg == 4'h0) ? 5'h00 : stk_src_reg[top_idx];

  // Only a strictly higher level may interrupt the one in service
  wire irq_go = best.found & (sp_reg != SP_FULL) &
                ((sp_reg == 4'h0) | (best.prio > cur_pri)); // [RULE_03]
  wire fiq_go = |(active & force_eff); // [RULE_06] [RULE_10]
  wire push = vec_rd & irq_go;
  wire pop = end_wr & (sp_reg != 4'h0);

  // Auto-clear of the taken source; of forced ones, only source 0, on a fast vector read
  wire [31:0] clr_vec = (clr_wr ? wdat : 32'h00000000) |
                        (push ? onehot(best.id) : 32'h00000000) |
                        (fvec_rd ? 32'h00000001 : 32'h00000000);
  wire [31:0] set_vec = set_wr ? wdat : 32'h00000000;

  // ----------------------------------------------------------------
  // Input stages
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NSRC; g++)
    begin : g_src
      irq_input_stage #(
        .EXTERNAL(EXT_SRC[g])
      ) u_stage (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .raw_in(src_raw[g]),
        .trig_type(trig_reg[g]), // [RULE_14]
        .sw_set(set_vec[g]), // [RULE_18]
        .sw_clr(clr_vec[g]),
        .pending(pend[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------
  wire [31:0] mode_word = {24'h000000, 1'b0, trig_reg[mode_idx],
                           2'b00, prio_reg[mode_idx]};
  wire [31:0] vec_word = push ? {27'h0000000, best.id} : SPURIOUS_VEC;
  wire [31:0] core_word = {30'h00000000, ~normal_n_reg, ~fast_n_reg};
  wire [31:0] rdata_next =
    ({32{hit_mode}} & mode_word) |
    ({32{adr == OFS_VECTOR}} & vec_word) |
    ({32{adr == OFS_CURRENT}} & {27'h0000000, cur_id}) |
    ({32{adr == OFS_PENDING}} & pend) |
    ({32{adr == OFS_MASK}} & mask_reg) |
    ({32{adr == OFS_CORE}} & core_word) |
    ({32{adr == OFS_GMASK}} & {31'h00000000, gmask_reg}) |
    ({32{adr == OFS_FORCE_STAT}} & force_eff);

  // ----------------------------------------------------------------
  // Bus slave: ack one cycle after the request, data registered
  // ----------------------------------------------------------------
  // Unmapped addresses are acked with zero data
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      ack_reg <= acc;
      rdata_reg <= rd ? rdata_next : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Free-running clk_sys, no enable from power control [RULE_07]
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      mask_reg <= MASK_RESET;
      force_reg <= MASK_RESET;
      gmask_reg <= 1'b0;
      for (int i = 0; i < NSRC; i++)
      begin
        prio_reg[i] <= PRIO_RESET;
        trig_reg[i] <= TRIG_RESET;
      end
    end
    else
    begin
      mask_reg <= (mask_reg | (en_wr ? wdat : 32'h0)) & ~(dis_wr ? wdat : 32'h0);
      force_reg <= (force_reg | (fon_wr ? wdat : 32'h0)) & ~(foff_wr ? wdat : 32'h0);
      if (gm_wr)
        gmask_reg <= wdat[0];
      if (mode_wr)
      begin
        prio_reg[mode_idx] <= wdat[PRIO_LSB +: 3]; // [RULE_16]
        trig_reg[mode_idx] <= wdat[TRIG_LSB +: 2]; // [RULE_14]
      end
    end
  end

  // ----------------------------------------------------------------
  // Nesting stack
  // ----------------------------------------------------------------
  // Entries hold data only; the pointer alone needs reset
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      sp_reg <= 4'h0;
    else if (push)
      sp_reg <= sp_reg + 4'h1; // [RULE_19]
    else if (pop)
      sp_reg <= sp_reg - 4'h1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      stk_src_reg[sp_reg[2:0]] <= best.id; // [RULE_19]
      stk_pri_reg[sp_reg[2:0]] <= best.prio;
    end
  end

  // ----------------------------------------------------------------
  // Request outputs
  // ----------------------------------------------------------------
  // Global mask keeps the lines quiet but still wakes the core
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      fast_n_reg <= 1'b1; // [RULE_21]
      normal_n_reg <= 1'b1;
      wake_reg <= 1'b0;
    end
    else
    begin
      fast_n_reg <= ~(fiq_go & ~gmask_reg); // [RULE_02] [RULE_09]
      normal_n_reg <= ~(irq_go & ~gmask_reg);
      wake_reg <= fiq_go | irq_go; // [RULE_08]
    end
  end

  assign fast_request_n = fast_n_reg;
  assign normal_request_n = normal_n_reg;
  assign wake_req = wake_reg;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_reset_quiet: assert property ( // [RULE_21]
    @(posedge clk_sys) !rst_n |=> fast_request_n && normal_request_n && !wake_req
  ) else $error("requests not idle after reset");

  chk_fast_drive: assert property ( // [RULE_06]
    @(posedge clk_sys) disable iff (!rst_n)
    fiq_go && !gmask_reg |=> !fast_request_n
  ) else $error("forced source did not raise fast request");

  chk_src0_fast: assert property ( // [RULE_10]
    @(posedge clk_sys) disable iff (!rst_n)
    pend[0] && mask_reg[0] && !gmask_reg |=> !fast_request_n
  ) else $error("source 0 did not raise fast request");

  chk_forced_off_std: assert property ( // [RULE_06]
    @(posedge clk_sys) disable iff (!rst_n)
    (norm_cand == 32'h0) |=> normal_request_n
  ) else $error("standard request with no standard candidate");

  chk_gmask_silent: assert property ( // [RULE_09]
    @(posedge clk_sys) disable iff (!rst_n)
    gmask_reg && (fiq_go || irq_go) |=> fast_request_n && normal_request_n && wake_req
  ) else $error("global mask did not hold lines while waking");

  chk_wake_follows: assert property ( // [RULE_08]
    @(posedge clk_sys) disable iff (!rst_n)
    !fast_request_n || !normal_request_n |-> wake_req
  ) else $error("request without wake");

  chk_stack_push: assert property ( // [RULE_19]
    @(posedge clk_sys) disable iff (!rst_n)
    push |=> sp_reg == $past(sp_reg) + 4'h1 && stk_src_reg[$past(top_idx) + 3'h1] == $past(best.id)
  ) else $error("stack push wrong");

  chk_stack_pop: assert property ( // [RULE_19]
    @(posedge clk_sys) disable iff (!rst_n)
    pop |=> sp_reg == $past(sp_reg) - 4'h1
  ) else $error("stack pop wrong");

  chk_nest_higher: assert property ( // [RULE_03]
    @(posedge clk_sys) disable iff (!rst_n)
    push ##1 (sp_reg < SP_FULL && !gmask_reg && best.found && best.prio > stk_pri_reg[top_idx])
    |=> !normal_request_n
  ) else $error("higher priority did not re-raise request");

  chk_edge_hold: assert property ( // [RULE_20]
    @(posedge clk_sys) disable iff (!rst_n)
    trig_reg[0][0] && pend[0] && !clr_vec[0] && !mode_wr |=> pend[0]
  ) else $error("latched edge lost without clear");

  chk_ack_pulse: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    acc |=> wb_ack_o ##1 !wb_ack_o
  ) else $error("ack not a single pulse");

endmodule

// ==== logic/irq_front_pkg.sv ====
// How it works
// [RULE_01] Thirty-two sources, each with mask and priority
// [RULE_02] Two active-low requests: fast and standard
// [RULE_03] Higher priority re-raises standard request while nested
// [RULE_04] Internal sources are level or edge triggered
// [RULE_05] External sources: rise, fall, high, low
// [RULE_06] Forced source drives fast request instead
// [RULE_07] Clock never gated; no power influence
// [RULE_08] Any asserted request wakes the processor
// [RULE_09] Global mask wakes without asserting request lines
// [RULE_10] Source 0 is the fast interrupt pin
// [RULE_11] Source 1 is OR of system lines
// [RULE_12] Sources 2-31 from peripherals or external pins
// [RULE_13] Source number equals peripheral identifier
// [RULE_14] Per-source mode register selects trigger type
// [RULE_15] Internal polarity handled by hardware
// [RULE_16] Priority 7 most urgent, 0 least
// [RULE_17] Ties go to the lowest source number
// [RULE_18] Set and clear act only on edge sources
// [RULE_19] Eight-deep stack of source and priority
// [RULE_20] External inputs synchronised; edges latched until cleared
// [RULE_21] Reset deasserts requests and clears edge latches
package irq_front_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NSRC = 32;
  localparam int STACK_DEPTH = 8;
  localparam int SYS_LINES = 8;
  localparam int NPER = 27;
  localparam int NEXT = 3;
  localparam logic [31:0] EXT_SRC = 32'hE0000001;
  localparam logic [3:0] SP_FULL = 4'h8;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_MODE_LAST = 12'h07C;
  localparam logic [11:0] OFS_VECTOR = 12'h100;
  localparam logic [11:0] OFS_FAST_VECTOR = 12'h104;
  localparam logic [11:0] OFS_CURRENT = 12'h108;
  localparam logic [11:0] OFS_PENDING = 12'h10C;
  localparam logic [11:0] OFS_MASK = 12'h110;
  localparam logic [11:0] OFS_CORE = 12'h114;
  localparam logic [11:0] OFS_ENABLE = 12'h120;
  localparam logic [11:0] OFS_DISABLE = 12'h124;
  localparam logic [11:0] OFS_SET = 12'h128;
  localparam logic [11:0] OFS_CLEAR = 12'h12C;
  localparam logic [11:0] OFS_END = 12'h130;
  localparam logic [11:0] OFS_GMASK = 12'h138;
  localparam logic [11:0] OFS_FORCE_ON = 12'h140;
  localparam logic [11:0] OFS_FORCE_OFF = 12'h144;
  localparam logic [11:0] OFS_FORCE_STAT = 12'h148;

  // ----------------------------------------------------------------
  // Mode register fields and reset values
  // ----------------------------------------------------------------
  localparam int PRIO_LSB = 0;
  localparam int TRIG_LSB = 5;
  localparam logic [2:0] PRIO_RESET = 3'h0;
  localparam logic [1:0] TRIG_RESET = 2'h0;
  localparam logic [31:0] MASK_RESET = 32'h00000000;
  localparam logic [31:0] SPURIOUS_VEC = 32'h000000FF;

  typedef enum logic [1:0] {
    TRIG_LOW_LEVEL = 2'b00,
    TRIG_FALL_EDGE = 2'b01,
    TRIG_HIGH_LEVEL = 2'b10,
    TRIG_RISE_EDGE = 2'b11
  } trig_e;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic found;
    logic [4:0] id;
    logic [2:0] prio;
  } pick_s;

endpackage

// ==== logic/irq_input_stage.sv ====
`timescale 1ns/1ps
module irq_input_stage
  import irq_front_pkg::*;
#(
  parameter bit EXTERNAL = 1'b0
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic raw_in,
  input wire logic [1:0] trig_type,
  input wire logic sw_set,
  input wire logic sw_clr,
  output logic pending
);

  logic lvl;
  logic prev_reg;
  logic latch_reg;
  logic latch_next;

  // ----------------------------------------------------------------
  // Level seen by the detector
  // ----------------------------------------------------------------
  generate
    if (EXTERNAL)
    begin : g_sync
      logic meta_reg;
      logic sync_reg;
      // Pins are asynchronous; two flops before any detection
      always_ff @(posedge clk_sys)
      begin
        if (!rst_n)
        begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end
        else
        begin
          meta_reg <= raw_in; // [RULE_20]
          sync_reg <= meta_reg;
        end
      end
      assign lvl = sync_reg;
    end
    else
    begin : g_direct
      assign lvl = raw_in;
    end
  endgenerate

  // Internal lines are always active high [RULE_15]
  wire is_edge = trig_type[0]; // [RULE_04] [RULE_05]
  wire active_high = EXTERNAL ? trig_type[1] : 1'b1;
  wire edge_hit = is_edge & (active_high ? (lvl & ~prev_reg) : (~lvl & prev_reg));

  // Set wins over clear; commands ignored in level mode
  assign latch_next = (edge_hit | (sw_set & is_edge)) ? 1'b1 : // [RULE_18]
                      (sw_clr | ~is_edge) ? 1'b0 : latch_reg;
  assign pending = is_edge ? latch_reg : (lvl == active_high);

  // Edge memory, cleared by reset
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      prev_reg <= 1'b0;
      latch_reg <= 1'b0; // [RULE_21]
    end
    else
    begin
      prev_reg <= lvl;
      latch_reg <= latch_next; // [RULE_20]
    end
  end

endmodule

// ==== bench/core_model.sv ====
`timescale 1ns/1ps
// ------------------------------------------------
// Processor core side: counts request assertions
// ------------------------------------------------
module core_model
  import irq_front_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic fast_request_n,
  input wire logic normal_request_n,
  input wire logic wake_req,
  output logic [7:0] fast_hits,
  output logic [7:0] normal_hits,
  output logic [7:0] wake_hits
);
  logic fast_reg;
  logic normal_reg;
  logic wake_reg;

  // Count each new assertion; a core sees only edges of these lines
  always_ff @(posedge clk_sys)
  begin
    fast_reg <= fast_request_n;
    normal_reg <= normal_request_n;
    wake_reg <= wake_req;
    if (!rst_n)
    begin
      fast_hits <= 8'h00;
      normal_hits <= 8'h00;
      wake_hits <= 8'h00;
    end
    else
    begin
      if (fast_reg && !fast_request_n) fast_hits <= fast_hits + 8'h01;
      if (normal_reg && !normal_request_n) normal_hits <= normal_hits + 8'h01;
      if (!wake_reg && wake_req) wake_hits <= wake_hits + 8'h01;
    end
  end
endmodule

// ==== bench/vectored_priority_interrupt_front_tb.sv ====
`timescale 1ns/1ps
module vectored_priority_interrupt_front_tb
  import irq_front_pkg::*;
;
  logic clk_sys;
  logic rst_n;
  wb_req_s wb_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic fast_irq_pin;
  logic [SYS_LINES-1:0] sys_irq_lines;
  logic [NPER-1:0] periph_irq;
  logic [NEXT-1:0] ext_irq_pin;
  logic fast_request_n;
  logic normal_request_n;
  logic wake_req;
  logic [7:0] normal_hits;
  logic [31:0] q;
  int err_count;
  int cmp_count;

  vectored_priority_interrupt_front dut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_i(wb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fast_irq_pin(fast_irq_pin),
    .sys_irq_lines(sys_irq_lines), .periph_irq(periph_irq), .ext_irq_pin(ext_irq_pin),
    .fast_request_n(fast_request_n), .normal_request_n(normal_request_n), .wake_req(wake_req));

  core_model core (.clk_sys(clk_sys), .rst_n(rst_n), .fast_request_n(fast_request_n),
    .normal_request_n(normal_request_n), .wake_req(wake_req), .fast_hits(),
    .normal_hits(normal_hits), .wake_hits());

  // ------------------------------------------------
  // Shared helpers
  // ------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One classic cycle; request held until ack is sampled high
  task automatic bus(input logic we, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_i <= {2'b11, we, a, 4'hF, d};
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 40);
    if (n >= 40) check("bus ack", 32'h1, 32'h0);
    q = wb_dat_o;
    wb_i <= '0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    check(what, exp, q);
  endtask

  // Mode register then enable command for one source
  task automatic cfg(input int n, input logic [2:0] p, input logic [1:0] t);
    bus(1'b1, 12'(4 * n), {25'h0, t, 2'h0, p});
    bus(1'b1, OFS_ENABLE, 32'h1 << n);
  endtask

  // Worst path is two sync flops, edge flop and output register
  task automatic settle();
    repeat (8) @(posedge clk_sys);
  endtask

  task automatic idle_all();
    periph_irq <= '0;
    sys_irq_lines <= '0;
    bus(1'b1, OFS_DISABLE, 32'hFFFFFFFF);
    bus(1'b1, OFS_CLEAR, 32'hFFFFFFFF);
  endtask

  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic t_reset();
    check("fast after reset", 32'h1, fast_request_n);
    check("normal after reset", 32'h1, normal_request_n);
    check("wake after reset", 32'h0, wake_req);
    rd(12'h008, 32'h0, "mode reset");
    rd(OFS_MASK, MASK_RESET, "mask reset");
    rd(12'h200, 32'h0, "unmapped read");
    rd(OFS_VECTOR, SPURIOUS_VEC, "spurious vector");
  endtask

  task automatic t_level();
    cfg(2, 3'h3, 2'b10);
    periph_irq[0] <= 1'b1;
    settle();
    check("level normal", 32'h0, normal_request_n);
    check("level wake", 32'h1, wake_req);
    rd(OFS_VECTOR, 32'h2, "level vector");
    settle();
    check("served normal", 32'h1, normal_request_n);
    periph_irq[0] <= 1'b0;
    bus(1'b1, OFS_END, 32'h0);
    idle_all();
  endtask

  task automatic t_nest();
    logic [7:0] h;
    h = normal_hits;
    cfg(3, 3'h2, 2'b10);
    cfg(4, 3'h5, 2'b10);
    periph_irq[1] <= 1'b1;
    settle();
    rd(OFS_VECTOR, 32'h3, "low vector");
    periph_irq[2] <= 1'b1;
    settle();
    check("nest normal", 32'h0, normal_request_n);
    check("nest hits", 32'(h + 8'h02), 32'(normal_hits));
    rd(OFS_VECTOR, 32'h4, "high vector");
    bus(1'b1, OFS_END, 32'h0);
    rd(OFS_CURRENT, 32'h3, "popped current");
    idle_all();
    bus(1'b1, OFS_END, 32'h0);
  endtask

  task automatic t_tie();
    cfg(5, 3'h0, 2'b10);
    cfg(6, 3'h7, 2'b10);
    cfg(7, 3'h7, 2'b10);
    periph_irq[5:3] <= 3'b111;
    settle();
    rd(OFS_VECTOR, 32'h6, "tie vector");
    idle_all();
    bus(1'b1, OFS_END, 32'h0);
  endtask

  task automatic t_int_edge();
    cfg(2, 3'h1, 2'b11);
    periph_irq[0] <= 1'b1;
    @(posedge clk_sys);
    periph_irq[0] <= 1'b0;
    settle();
    check("latched edge", 32'h0, normal_request_n);
    rd(OFS_VECTOR, 32'h2, "edge vector");
    bus(1'b1, OFS_END, 32'h0);
    settle();
    check("auto clear", 32'h1, normal_request_n);
    idle_all();
  endtask

  // One external source through all four trigger kinds
  task automatic t_ext(input logic [1:0] t);
    logic idle;
    idle = ~t[1];
    ext_irq_pin[0] <= idle;
    settle();
    cfg(29, 3'h4, t);
    bus(1'b1, OFS_CLEAR, 32'h1 << 29);
    settle();
    check("ext idle", 32'h1, normal_request_n);
    ext_irq_pin[0] <= ~idle;
    settle();
    check("ext active", 32'h0, normal_request_n);
    ext_irq_pin[0] <= idle;
    settle();
    check("ext after", {31'h0, ~t[0]}, normal_request_n);
    bus(1'b1, OFS_SET, 32'h1 << 29);
    settle();
    check("ext set", {31'h0, ~t[0]}, normal_request_n);
    bus(1'b1, OFS_CLEAR, 32'h1 << 29);
    settle();
    check("ext clear", 32'h1, normal_request_n);
    idle_all();
  endtask

  task automatic t_force();
    bus(1'b1, OFS_FORCE_ON, 32'h4);
    cfg(2, 3'h1, 2'b10);
    periph_irq[0] <= 1'b1;
    settle();
    check("forced fast", 32'h0, fast_request_n);
    check("forced normal", 32'h1, normal_request_n);
    rd(OFS_FORCE_STAT, 32'h5, "force status");
    idle_all();
    bus(1'b1, OFS_FORCE_OFF, 32'h4);
    cfg(0, 3'h0, 2'b00);
    fast_irq_pin <= 1'b0;
    settle();
    check("pin fast", 32'h0, fast_request_n);
    rd(OFS_CORE, 32'h1, "core status");
    fast_irq_pin <= 1'b1;
    // Source 0 as a falling edge: latched, then freed by the fast vector read
    cfg(0, 3'h0, 2'b01);
    fast_irq_pin <= 1'b0;
    settle();
    fast_irq_pin <= 1'b1;
    settle();
    check("fast latched", 32'h0, fast_request_n);
    rd(OFS_FAST_VECTOR, 32'h0, "fast vector");
    settle();
    check("fast cleared", 32'h1, fast_request_n);
    idle_all();
  endtask

  task automatic t_sys_gmask();
    cfg(1, 3'h1, 2'b10);
    sys_irq_lines <= 8'h20;
    settle();
    rd(OFS_VECTOR, 32'h1, "system vector");
    idle_all();
    bus(1'b1, OFS_END, 32'h0);
    bus(1'b1, OFS_GMASK, 32'h1);
    cfg(3, 3'h1, 2'b10);
    periph_irq[1] <= 1'b1;
    settle();
    check("gmask normal", 32'h1, normal_request_n);
    check("gmask wake", 32'h1, wake_req);
    rd(OFS_GMASK, 32'h1, "gmask read");
    rd(OFS_PENDING, 32'h8, "pending");
    bus(1'b1, OFS_GMASK, 32'h0);
    idle_all();
  endtask

  // Reset in mid-run drops a latched edge, the standard request and wake
  task automatic t_midreset();
    ext_irq_pin <= '1;
    cfg(2, 3'h1, 2'b11);
    periph_irq[0] <= 1'b1;
    @(posedge clk_sys);
    periph_irq[0] <= 1'b0;
    settle();
    check("edge before reset", 32'h0, normal_request_n);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    check("normal after mid reset", 32'h1, normal_request_n);
    check("wake after mid reset", 32'h0, wake_req);
    rd(OFS_PENDING, 32'h0, "pending after reset");
    rd(OFS_MASK, MASK_RESET, "mask after reset");
  endtask

  // ------------------------------------------------
  // Clock, reset, sequence and verdict
  // ------------------------------------------------
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Free running system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Cut a hang short well beyond the several hundred cycles needed
  initial
  begin
    #400000;
    err_count++;
    print_verdict();
  end

  initial
  begin
    rst_n = 1'b0;
    wb_i = '0;
    fast_irq_pin = 1'b1;
    sys_irq_lines = '0;
    periph_irq = '0;
    ext_irq_pin = '1;
    err_count = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_level();
    t_nest();
    t_tie();
    t_int_edge();
    for (int t = 0; t < 4; t++) t_ext(2'(t));
    t_force();
    t_sys_gmask();
    t_midreset();
    print_verdict();
  end
endmodule
